/* inc/ampb_cfg.svh */
`ifndef AMPB_CFG_SVH
`define AMPB_CFG_SVH
`define AMPB_DATA_W      8
`define AMPB_ADDR_W      4
`define AMPB_NREGS       16
// shared address: read gives receive, write goes to transmit
`define AMPB_ADDR_XFER   4'hd
// implemented bit mask per register (all bits of the scratch set)
`define AMPB_IMPL_MASK   8'hff
// host access phase length in clocks
`define AMPB_HOLD_CYC    4
// reset values of data, address and register file entries
`define AMPB_RST_DATA    8'h00
`define AMPB_RST_ADDR    4'h0
// clocks until the strobe pipeline holds values taken after reset
`define AMPB_SYNC_FILL   3
`endif

/* inc/ampb_pkg.sv */
package ampb_pkg;
	typedef enum logic {AMPB_NONMUX, AMPB_MUX} ampb_mode_t;
	typedef logic [7:0] ampb_byte_t;
	typedef logic [3:0] ampb_addr_t;
endpackage

/* inc/ampb_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ampb_if;
	logic       ale;
	logic       cs_n;
	logic       rd_n;
	logic       wr_n;
	logic [3:0] register_select_lines;
	logic [7:0] dev_data_out;
	logic       dev_data_oe_n;
	logic [7:0] host_data_out;
	logic       host_data_oe_n;
	logic [7:0] host_data_lines;
	logic       int_n;
	assign host_data_lines = !dev_data_oe_n ? dev_data_out :
		(!host_data_oe_n ? host_data_out : 8'hff);
	modport dev (input ale, cs_n, rd_n, wr_n, register_select_lines,
		host_data_lines, output dev_data_out, dev_data_oe_n, int_n);
	modport host (output ale, cs_n, rd_n, wr_n, register_select_lines,
		host_data_out, host_data_oe_n, input host_data_lines, int_n);
endinterface
`default_nettype wire

/* design/ampb_dev.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ampb_cfg.svh"
// Summary of operation
// - reset and idle strobe give nonmultiplexed
// - rising strobe edge enters multiplexed mode
// - reset or chip deselect leaves multiplexed
// - host ties strobe steady for nonmultiplexed
// - falling strobe captures low data nibble
// - address latched regardless of chip select
// - multiplexed read/write strobes qualified by select
// - nonmux address on select lines, data bytewide
// - nonmux read strobe level picks direction
// - nonmux access needs store and select low
// - interrupt output low while any source
// - board ties select lines in multiplexed
// - side alert input is interrupt source
// - shared address splits receive and transmit
// - unimplemented bits write nothing, read zero
module ampb_dev
	import ampb_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// host bus
	ampb_if.dev             bus,
	// user side
	input  wire logic       side_alert_in,
	input  wire logic       irq_src,
	input  wire logic [7:0] rx_data,
	output logic      [7:0] tx_data,
	output logic            tx_strobe,
	output logic            rx_strobe,
	output logic      [3:0] mode_mux
);
	// strobes as one vector, msb first: ale, cs_n, rd_n, wr_n
	logic [3:0] sync0_reg, sync0_next;
	logic [3:0] sync1_reg, sync1_next;
	// previous synced ale (bit 1) and cs_n (bit 0) for edges
	logic [1:0] prev_reg, prev_next;
	logic [1:0] fill_reg, fill_next;
	logic       armed;
	logic       ale_s, cs_n_s, rd_n_s, wr_n_s;
	logic       ale_rise, ale_fall, cs_rise;
	// mode and latched address
	ampb_mode_t mode_reg, mode_next;
	ampb_addr_t addr_reg, addr_next;
	// access state
	ampb_byte_t dout_reg, dout_next;
	ampb_byte_t tx_reg, tx_next;
	logic       act_reg, act_next;
	logic       tx_stb_reg, tx_stb_next;
	logic       rx_stb_reg, rx_stb_next;
	logic       oe_n_reg, oe_n_next;
	logic       acc, is_rd, is_wr, first, xfer, wr_now;
	ampb_addr_t a;
	// register file
	ampb_byte_t regs [`AMPB_NREGS];
	ampb_byte_t regs_next [`AMPB_NREGS];
	logic [`AMPB_NREGS-1:0] wr_hit;
	ampb_byte_t wdata_impl;

	// two stages against metastability; only the second stage is read
	always_comb begin
		sync0_next = {bus.ale, bus.cs_n, bus.rd_n, bus.wr_n};
		sync1_next = sync0_reg;
		prev_next  = sync1_reg[3:2];
		if (fill_reg == 2'(`AMPB_SYNC_FILL)) begin
			fill_next = fill_reg;
		end else begin
			fill_next = fill_reg + 2'h1;
		end
	end

	// the chain has no reset so it follows the pins during reset
	always_ff @(posedge clk) begin
		sync0_reg <= sync0_next;
		sync1_reg <= sync1_next;
		prev_reg  <= prev_next;
		if (rst) begin
			fill_reg <= 2'h0;
		end else begin
			fill_reg <= fill_next;
		end
	end

	assign {ale_s, cs_n_s, rd_n_s, wr_n_s} = sync1_reg;
	// edges count only once the chain holds pins taken after reset, so a
	// strobe tied high cannot pass for a rising edge after a short reset
	assign armed    = (fill_reg == 2'(`AMPB_SYNC_FILL));
	assign ale_rise = armed && ale_s && !prev_reg[1];
	assign ale_fall = armed && !ale_s && prev_reg[1];
	assign cs_rise  = armed && cs_n_s && !prev_reg[0];

	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			AMPB_NONMUX: begin
				if (ale_rise) begin
					mode_next = AMPB_MUX;
				end
			end
			AMPB_MUX: begin
				if (cs_rise) begin
					mode_next = AMPB_NONMUX;
				end
			end
			default: begin
				mode_next = AMPB_NONMUX;
			end
		endcase
		addr_next = addr_reg;
		// no chip select term here on purpose
		if (ale_fall) begin
			addr_next = bus.host_data_lines[3:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mode_reg <= AMPB_NONMUX;
			addr_reg <= `AMPB_RST_ADDR;
		end else begin
			mode_reg <= mode_next;
			addr_reg <= addr_next;
		end
	end

	always_comb begin
		if (mode_reg == AMPB_MUX) begin
			a = addr_reg;
		end else begin
			a = bus.register_select_lines;
		end
		if (mode_reg == AMPB_MUX) begin
			is_rd = !cs_n_s && !rd_n_s;
			is_wr = !cs_n_s && !wr_n_s && rd_n_s;
		end else begin
			is_rd = !cs_n_s && !wr_n_s && rd_n_s;
			is_wr = !cs_n_s && !wr_n_s && !rd_n_s;
		end
		acc   = is_rd || is_wr;
		// one action per strobe assertion, however long it is held
		first = acc && !act_reg;
		xfer  = (a == `AMPB_ADDR_XFER);
		act_next    = acc;
		oe_n_next   = !is_rd;
		dout_next   = dout_reg;
		tx_next     = tx_reg;
		tx_stb_next = 1'b0;
		rx_stb_next = 1'b0;
		wr_now      = 1'b0;
		if (first && is_rd) begin
			if (xfer) begin
				dout_next   = rx_data;
				rx_stb_next = 1'b1;
			end else begin
				dout_next = regs[a] & `AMPB_IMPL_MASK;
			end
		end
		if (first && is_wr) begin
			if (xfer) begin
				tx_next     = bus.host_data_lines;
				tx_stb_next = 1'b1;
			end else begin
				wr_now = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dout_reg   <= `AMPB_RST_DATA;
			tx_reg     <= `AMPB_RST_DATA;
			act_reg    <= 1'b0;
			oe_n_reg   <= 1'b1;
			tx_stb_reg <= 1'b0;
			rx_stb_reg <= 1'b0;
		end else begin
			dout_reg   <= dout_next;
			tx_reg     <= tx_next;
			act_reg    <= act_next;
			oe_n_reg   <= oe_n_next;
			tx_stb_reg <= tx_stb_next;
			rx_stb_reg <= rx_stb_next;
		end
	end

	// unimplemented bits are masked on the way in as well as out
	assign wdata_impl = bus.host_data_lines & `AMPB_IMPL_MASK;

	for (genvar i = 0; i < `AMPB_NREGS; i++) begin : g_entry
		assign wr_hit[i]    = wr_now && (a == 4'(i));
		assign regs_next[i] = wr_hit[i] ? wdata_impl : regs[i];
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < `AMPB_NREGS; i++) begin
			if (rst) begin
				regs[i] <= `AMPB_RST_DATA;
			end else begin
				regs[i] <= regs_next[i];
			end
		end
	end

	assign bus.dev_data_out  = dout_reg;
	assign bus.dev_data_oe_n = oe_n_reg;
	assign bus.int_n = !(side_alert_in || irq_src);
	assign tx_data   = tx_reg;
	assign tx_strobe = tx_stb_reg;
	assign rx_strobe = rx_stb_reg;
	assign mode_mux  = {3'h0, mode_reg == AMPB_MUX};
endmodule // ampb_dev
`default_nettype wire

/* design/ampb_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ampb_cfg.svh"
module ampb_host
	import ampb_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// host bus
	ampb_if.host            bus,
	// user side
	input  wire logic       use_mux,
	input  wire logic       req,
	input  wire logic       req_write,
	input  wire logic [3:0] req_addr,
	input  wire logic [7:0] req_wdata,
	output logic            busy,
	output logic            done,
	output logic      [7:0] rdata,
	output logic            irq
);
	typedef enum logic [2:0] {H_IDLE, H_ALE, H_ADR, H_ACC, H_END}
		ampb_hst_t;
	ampb_hst_t  st_reg, st_next;
	logic [3:0] cnt_reg, cnt_next;
	logic       wr_reg, wr_next, mux_reg, mux_next, done_reg, done_next;
	ampb_addr_t a_reg, a_next;
	ampb_byte_t w_reg, w_next, r_reg, r_next;
	logic       last;

	assign last = (cnt_reg == 4'(`AMPB_HOLD_CYC - 1));

	always_comb begin
		st_next = st_reg;
		cnt_next = last ? 4'h0 : cnt_reg + 4'h1;
		wr_next = wr_reg;
		mux_next = mux_reg;
		a_next = a_reg;
		w_next = w_reg;
		r_next = r_reg;
		done_next = 1'b0;
		case (st_reg)
			H_IDLE: begin
				cnt_next = 4'h0;
				if (req) begin
					wr_next = req_write;
					mux_next = use_mux;
					a_next = req_addr;
					w_next = req_wdata;
					st_next = use_mux ? H_ALE : H_ACC;
				end
			end
			H_ALE: if (last) st_next = H_ADR;
			H_ADR: if (last) st_next = H_ACC;
			H_ACC: if (last) begin
				if (!wr_reg)
					r_next = bus.host_data_lines;
				st_next = H_END;
			end
			H_END: if (last) begin
				done_next = 1'b1;
				st_next = H_IDLE;
			end
			default: st_next = H_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= H_IDLE;
			cnt_reg <= 4'h0;
			wr_reg <= 1'b0;
			mux_reg <= 1'b0;
			a_reg <= `AMPB_RST_ADDR;
			w_reg <= `AMPB_RST_DATA;
			r_reg <= `AMPB_RST_DATA;
			done_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			wr_reg <= wr_next;
			mux_reg <= mux_next;
			a_reg <= a_next;
			w_reg <= w_next;
			r_reg <= r_next;
			done_reg <= done_next;
		end
	end

	// nonmux keeps the strobe low so the device never leaves that mode
	assign bus.ale = mux_reg && (st_reg == H_ALE);
	assign bus.cs_n = !(st_reg == H_ACC);
	assign bus.wr_n = mux_reg ? !(st_reg == H_ACC && wr_reg)
		: !(st_reg == H_ACC);
	assign bus.rd_n = mux_reg ? !(st_reg == H_ACC && !wr_reg)
		: !wr_reg;
	assign bus.register_select_lines = mux_reg ? 4'h0 : a_reg;
	assign bus.host_data_out = (st_reg == H_ALE || st_reg == H_ADR)
		? {4'h0, a_reg} : w_reg;
	assign bus.host_data_oe_n = !(st_reg == H_ALE || st_reg == H_ADR
		|| (wr_reg && (st_reg == H_ACC || st_reg == H_END)));
	assign busy  = (st_reg != H_IDLE);
	assign done  = done_reg;
	assign rdata = r_reg;
	assign irq   = !bus.int_n;
endmodule // ampb_host
`default_nettype wire

/* dv/ampb_props.sv */
`timescale 1ns/1ps
`default_nettype none
module ampb_props (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bus
	input wire logic ale,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic dev_data_oe_n,
	input wire logic host_data_oe_n,
	input wire logic int_n,
	// interrupt sources
	input wire logic side_alert_in,
	input wire logic irq_src
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence mux_rd;
		$fell(ale) ##[1:6] ($fell(rd_n) && wr_n && !cs_n);
	endsequence
	sequence mux_wr;
		$fell(ale) ##[1:6] ($fell(wr_n) && rd_n && !cs_n);
	endsequence
	// a mux write looks like a plain read on the pins; quiet ale tells
	sequence plain_rd;
		!ale [*8] ##1 ($fell(wr_n) && rd_n && !cs_n);
	endsequence
	irq_on_a: assert property (
		(side_alert_in || irq_src) [*4] |-> !int_n) else $error("irq low");
	irq_off_a: assert property (
		!(side_alert_in || irq_src) [*4] |-> int_n) else $error("irq high");
	rst_quiet_a: assert property (
		$fell(rst) |-> dev_data_oe_n [*3]) else $error("drive at reset");
	idle_no_drive_a: assert property (
		cs_n [*4] |-> dev_data_oe_n) else $error("drive unselected");
	plain_wr_a: assert property (
		$fell(wr_n) && !rd_n && !cs_n |-> dev_data_oe_n [*4])
		else $error("drive on write");
	plain_rd_a: assert property (
		plain_rd |-> ##[1:4] !dev_data_oe_n) else $error("no read drive");
	mux_rd_a: assert property (
		mux_rd |-> ##[1:4] !dev_data_oe_n) else $error("no mux read");
	mux_wr_a: assert property (
		mux_wr |-> dev_data_oe_n [*4]) else $error("drive on mux write");
	no_clash_a: assert property (
		!dev_data_oe_n |-> host_data_oe_n) else $error("bus clash");
endmodule // ampb_props
`default_nettype wire

/* dv/test_auto_mux_parallel_host_bus.sv */
`timescale 1ns/1ps
`default_nettype none
module test_auto_mux_parallel_host_bus;
	import ampb_pkg::*;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       side_alert_in = 1'b0;
	logic       irq_src = 1'b0;
	logic [7:0] rx_data = 8'h00;
	logic       use_mux = 1'b0;
	logic       req = 1'b0;
	logic       req_write = 1'b0;
	logic [3:0] req_addr = 4'h0;
	logic [7:0] req_wdata = 8'h00;
	logic       busy, done, irq, tx_strobe, rx_strobe;
	logic [7:0] rdata, tx_data, got;
	logic [3:0] mode_mux;
	logic       mux_seen = 1'b0;
	int         miscompares = 0;
	int         check_count = 0;
	int         tx_cnt = 0;
	int         rx_cnt = 0;
	ampb_if u_ampb_if ();
	ampb_dev u_ampb_dev (.clk, .rst, .bus(u_ampb_if), .side_alert_in,
		.irq_src, .rx_data, .tx_data, .tx_strobe, .rx_strobe, .mode_mux);
	ampb_host u_ampb_host (.clk, .rst, .bus(u_ampb_if), .use_mux, .req,
		.req_write, .req_addr, .req_wdata, .busy, .done, .rdata, .irq);
	ampb_props u_ampb_props (.clk, .rst, .ale(u_ampb_if.ale),
		.cs_n(u_ampb_if.cs_n), .rd_n(u_ampb_if.rd_n),
		.wr_n(u_ampb_if.wr_n), .dev_data_oe_n(u_ampb_if.dev_data_oe_n),
		.host_data_oe_n(u_ampb_if.host_data_oe_n),
		.int_n(u_ampb_if.int_n), .side_alert_in, .irq_src);
	always #50 clk = ~clk;
	always @(posedge clk) begin
		tx_cnt += int'(tx_strobe === 1'b1);
		rx_cnt += int'(rx_strobe === 1'b1);
		mux_seen |= (mode_mux[0] === 1'b1);
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks=%0d miscompares=%0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one host transfer; req is a level, so drop it once taken
	task automatic access(input logic m, input logic w, input logic [3:0] a,
		input logic [7:0] d);
		int n;
		use_mux = m;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		req = 1'b1;
		@(posedge clk);
		#1 req = 1'b0;
		check({7'h0, busy}, 8'h01);
		n = 0;
		while (done !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1 n++;
		end
		miscompares += int'(n == 40);
		got = rdata;
		check({7'h0, busy}, 8'h00);
		@(posedge clk);
		#1;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		#1 rst = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		// write in one mode, read back in the other
		for (logic [4:0] a = 0; a < 16; a++) begin
			if (a != 13) begin
				access(a[0], 1'b1, a[3:0], {a[3:0], ~a[3:0]});
				access(~a[0], 1'b0, a[3:0], 8'h00);
				check(got, {a[3:0], ~a[3:0]});
			end
		end
		check({7'h0, mux_seen}, 8'h01);
		check({4'h0, mode_mux}, 8'h00);
		for (logic [1:0] m = 0; m < 2; m++) begin
			rx_data = 8'h5a ^ {7'h0, m[0]};
			access(m[0], 1'b1, 4'hd, 8'ha5 ^ {7'h0, m[0]});
			check(tx_data, 8'ha5 ^ {7'h0, m[0]});
			access(m[0], 1'b0, 4'hd, 8'h00);
			check(got, 8'h5a ^ {7'h0, m[0]});
		end
		check(8'(tx_cnt), 8'h02);
		check(8'(rx_cnt), 8'h02);
		for (logic [2:0] k = 0; k < 5; k++) begin
			{side_alert_in, irq_src} = k[1:0];
			repeat (6) @(posedge clk);
			#1 check({7'h0, irq}, {7'h0, k[1:0] != 2'b00});
		end
		finish_test();
	end
	initial begin
		repeat (3000) @(posedge clk);
		miscompares++;
		finish_test();
	end
endmodule // test_auto_mux_parallel_host_bus
`default_nettype wire
